/* src/rklg_pkg.sv */
// Package with encodings and reset values for the remote keypad lock gate.
package rklg_pkg;

   // Remote key codes delivered by the infrared decoder.
   typedef enum logic [2:0]
   {
      RKLG_KEY_NONE = 3'h0,
      RKLG_KEY_ON   = 3'h1,
      RKLG_KEY_AUTO = 3'h2,
      RKLG_KEY_OFF  = 3'h3,
      RKLG_KEY_TEST = 3'h4,
      RKLG_KEY_SET  = 3'h5
   } rklg_key_t;

   // Lock start choice after bus supply return.
   typedef enum logic [1:0]
   {
      RKLG_START_UNLOCKED = 2'h0,
      RKLG_START_LOCKED   = 2'h1,
      RKLG_START_RETAINED = 2'h2
   } rklg_start_t;

   // Reset values.
   localparam logic       VLD_RST  = 1'h0;
   localparam logic       LOCK_RST = 1'h0;
   localparam logic       SAVE_RST = 1'h0;
   localparam logic       WALK_RST = 1'h0;
   localparam logic [2:0] KEY_RST  = 3'h0;
   localparam logic [7:0] ARG_RST  = 8'h00;

   // Key argument width.
   localparam int ARG_W = 8;

endpackage : rklg_pkg

/* src/rklg_lock.sv */
// Lock state holder: telegram polarity, start-up choices and retention.
`timescale 1ns/1ps
module rklg_lock
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Configuration
   input  wire logic        lock_enable,
   input  wire logic        lock_polarity,
   input  wire logic [1:0]  start_supply,
   input  wire logic        start_download,
   // Events
   input  wire logic        lock_wr,
   input  wire logic        lock_value,
   input  wire logic        supply_fail,
   input  wire logic        supply_return,
   input  wire logic        download_done,
   // State
   output logic             locked
);

   typedef struct packed
   {
      logic lock;
      logic save;
   } rklg_lock_st_t;

   rklg_lock_st_t st;
   rklg_lock_st_t next_st;

   always_comb
   begin
      next_st = st;
      // Polarity 0 means 1 locks; polarity 1 means 0 locks.
      if (lock_wr)
      begin
         next_st.lock = lock_value ^ lock_polarity;
      end
      if (supply_fail)
      begin
         next_st.save = st.lock;
      end
      if (supply_return)
      begin
         case (rklg_pkg::rklg_start_t'(start_supply))
            rklg_pkg::RKLG_START_UNLOCKED: next_st.lock = 1'h0;
            rklg_pkg::RKLG_START_LOCKED:   next_st.lock = 1'h1;
            rklg_pkg::RKLG_START_RETAINED: next_st.lock = st.save;
            default:                       next_st.lock = 1'h0;
         endcase
      end
      if (download_done)
      begin
         next_st.lock = start_download;
      end
      // A disabled lock feature can never hold the remote locked.
      if (!lock_enable)
      begin
         next_st.lock = 1'h0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st.lock <= rklg_pkg::LOCK_RST;
         st.save <= rklg_pkg::SAVE_RST;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign locked = st.lock;

   disabled_free_a: assert property (@(posedge clk) disable iff (rst)
      !lock_enable |=> !locked)
      else $error("Lock held while feature disabled.");
   polarity_map_a: assert property (@(posedge clk) disable iff (rst)
      lock_enable && lock_wr && !supply_return && !download_done
      |=> locked == ($past(lock_value) ^ $past(lock_polarity)))
      else $error("Lock telegram polarity wrong.");
   retain_restore_a: assert property (@(posedge clk) disable iff (rst)
      lock_enable && supply_return && !download_done && start_supply == 2'h2 |=> locked == $past(st.save))
      else $error("Retained lock state not restored.");
   download_start_a: assert property (@(posedge clk) disable iff (rst)
      lock_enable && download_done |=> locked == $past(start_download))
      else $error("Download start state wrong.");

endmodule : rklg_lock

/* src/rklg_gate.sv */
// Remote keypad lock gate: filters decoded remote keys toward function block 1.
`timescale 1ns/1ps
// Notes on behaviour
// - On, automatic and off keys can each be switched off; switched-off keys are ignored.
// - Test key toggles walking test only when the key is made available.
// - Lock input works only when lock feature is enabled; else never locked.
// - While locked, every remote key is discarded.
// - Polarity setting selects whether telegram 1 or 0 locks.
// - After supply return, start unlocked or locked as configured.
// - Retention saves lock at supply failure and restores it on return.
// - After configuration download, start unlocked or locked per its own setting.
// - Remote keys are accepted only when remote operation is enabled.
// - Accepted keys go to function block 1 only.
module rklg_gate
(
   // Clock and reset
   input  wire logic                        CLK,
   input  wire logic                        RST,
   // Configuration
   input  wire logic                        REMOTE_ENABLE,
   input  wire logic                        KEY_ON_ENABLE,
   input  wire logic                        KEY_AUTO_ENABLE,
   input  wire logic                        KEY_OFF_ENABLE,
   input  wire logic                        KEY_TEST_ENABLE,
   input  wire logic                        LOCK_ENABLE,
   input  wire logic                        LOCK_POLARITY,
   input  wire logic [1:0]                  LOCK_START_SUPPLY,
   input  wire logic                        LOCK_START_DOWNLOAD,
   // Bus lock telegram (remote_lock_input object)
   input  wire logic                        REMOTE_LOCK_INPUT_WR,
   input  wire logic                        REMOTE_LOCK_INPUT,
   // Supply and download events
   input  wire logic                        SUPPLY_FAIL,
   input  wire logic                        SUPPLY_RETURN,
   input  wire logic                        DOWNLOAD_DONE,
   // Decoded remote keys
   input  wire logic                        KEY_VALID,
   input  wire logic [2:0]                  KEY_CODE,
   input  wire logic [rklg_pkg::ARG_W-1:0]  KEY_ARG,
   // Function block 1 command port
   output logic                             FB1_CMD_VALID,
   output logic [2:0]                       FB1_CMD_CODE,
   output logic [rklg_pkg::ARG_W-1:0]       FB1_CMD_ARG,
   output logic                             FB1_WALK_TEST,
   // Status
   output logic                             REMOTE_LOCKED
);

   typedef struct packed
   {
      logic                       vld;
      logic [2:0]                 code;
      logic [rklg_pkg::ARG_W-1:0] arg;
      logic                       walk;
      logic                       lock_q;
   } rklg_gate_st_t;

   rklg_gate_st_t st;
   rklg_gate_st_t next_st;
   logic          locked;
   logic          accept;

   // Returns whether a key code is permitted by the per-key configuration.
   function automatic logic key_allowed(input logic [2:0] code);
      case (rklg_pkg::rklg_key_t'(code))
         rklg_pkg::RKLG_KEY_ON:   key_allowed = KEY_ON_ENABLE;
         rklg_pkg::RKLG_KEY_AUTO: key_allowed = KEY_AUTO_ENABLE;
         rklg_pkg::RKLG_KEY_OFF:  key_allowed = KEY_OFF_ENABLE;
         rklg_pkg::RKLG_KEY_TEST: key_allowed = KEY_TEST_ENABLE;
         rklg_pkg::RKLG_KEY_NONE: key_allowed = 1'h0;
         default:                 key_allowed = 1'h1;
      endcase
   endfunction : key_allowed

   rklg_lock u_lock
   (
      .clk            (CLK),
      .rst            (RST),
      .lock_enable    (LOCK_ENABLE),
      .lock_polarity  (LOCK_POLARITY),
      .start_supply   (LOCK_START_SUPPLY),
      .start_download (LOCK_START_DOWNLOAD),
      .lock_wr        (REMOTE_LOCK_INPUT_WR),
      .lock_value     (REMOTE_LOCK_INPUT),
      .supply_fail    (SUPPLY_FAIL),
      .supply_return  (SUPPLY_RETURN),
      .download_done  (DOWNLOAD_DONE),
      .locked         (locked)
   );

   // Start-up choices, seen from the lock state that gates the keys.
   supply_open_a: assert property (@(posedge CLK) disable iff (RST)
      LOCK_ENABLE && SUPPLY_RETURN && !DOWNLOAD_DONE && LOCK_START_SUPPLY == 2'h0 |=> !locked)
      else $error("Remote not unlocked after supply return.");
   supply_lock_a: assert property (@(posedge CLK) disable iff (RST)
      LOCK_ENABLE && SUPPLY_RETURN && !DOWNLOAD_DONE && LOCK_START_SUPPLY == 2'h1 |=> locked)
      else $error("Remote not locked after supply return.");
   download_open_a: assert property (@(posedge CLK) disable iff (RST)
      LOCK_ENABLE && DOWNLOAD_DONE && !LOCK_START_DOWNLOAD |=> !locked)
      else $error("Remote not unlocked after download.");
   download_lock_a: assert property (@(posedge CLK) disable iff (RST)
      LOCK_ENABLE && DOWNLOAD_DONE && LOCK_START_DOWNLOAD |=> locked)
      else $error("Remote not locked after download.");

   // The registered lock is sampled when a key arrives, so a telegram in the
   // same cycle acts from the following key on and never splits one key.
   assign accept = KEY_VALID && REMOTE_ENABLE && !locked && key_allowed(KEY_CODE);

   always_comb
   begin
      next_st        = st;
      next_st.vld    = 1'h0;
      next_st.lock_q = locked;
      // Leaving remote operation ends a walking test that the remote started,
      // since no key could stop it afterwards.
      if (!REMOTE_ENABLE)
      begin
         next_st.walk = 1'h0;
      end
      if (accept)
      begin
         // Only function block 1 is wired here; no other block sees keys.
         next_st.vld  = 1'h1;
         next_st.code = KEY_CODE;
         next_st.arg  = KEY_ARG;
         if (KEY_CODE == rklg_pkg::RKLG_KEY_TEST)
         begin
            next_st.walk = !st.walk;
         end
      end
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         st.vld    <= rklg_pkg::VLD_RST;
         st.code   <= rklg_pkg::KEY_RST;
         st.arg    <= rklg_pkg::ARG_RST;
         st.walk   <= rklg_pkg::WALK_RST;
         st.lock_q <= rklg_pkg::LOCK_RST;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign FB1_CMD_VALID = st.vld;
   assign FB1_CMD_CODE  = st.code;
   assign FB1_CMD_ARG   = st.arg;
   assign FB1_WALK_TEST = st.walk;
   assign REMOTE_LOCKED = st.lock_q;

   // Key filtering: switched-off keys, the test key and the remote enable.
   key_masked_a: assert property (@(posedge CLK) disable iff (RST)
      KEY_VALID && KEY_CODE == 3'h1 && !KEY_ON_ENABLE |=> !FB1_CMD_VALID)
      else $error("Switched-off key passed.");
   auto_masked_a: assert property (@(posedge CLK) disable iff (RST)
      KEY_VALID && KEY_CODE == 3'h2 && !KEY_AUTO_ENABLE |=> !FB1_CMD_VALID)
      else $error("Switched-off automatic key passed.");
   off_masked_a: assert property (@(posedge CLK) disable iff (RST)
      KEY_VALID && KEY_CODE == 3'h3 && !KEY_OFF_ENABLE |=> !FB1_CMD_VALID)
      else $error("Switched-off off key passed.");
   test_blocked_a: assert property (@(posedge CLK) disable iff (RST)
      KEY_VALID && KEY_CODE == 3'h4 && !KEY_TEST_ENABLE && REMOTE_ENABLE |=> $stable(FB1_WALK_TEST))
      else $error("Unavailable test key changed walking test.");
   test_toggle_a: assert property (@(posedge CLK) disable iff (RST)
      accept && KEY_CODE == 3'h4 |=> FB1_WALK_TEST != $past(FB1_WALK_TEST))
      else $error("Test key did not toggle walking test.");
   remote_off_a: assert property (@(posedge CLK) disable iff (RST)
      !REMOTE_ENABLE |=> !FB1_CMD_VALID)
      else $error("Key passed with remote disabled.");
   remote_walk_a: assert property (@(posedge CLK) disable iff (RST)
      !REMOTE_ENABLE |=> !FB1_WALK_TEST)
      else $error("Walking test held with remote disabled.");

   // Lock: nothing passes while it holds, and the walking test stays put while remote operation is enabled.
   lock_discard_a: assert property (@(posedge CLK) disable iff (RST)
      locked |=> !FB1_CMD_VALID)
      else $error("Key passed while locked.");
   walk_frozen_a: assert property (@(posedge CLK) disable iff (RST)
      locked && REMOTE_ENABLE |=> $stable(FB1_WALK_TEST))
      else $error("Walking test changed while locked.");
   lock_status_a: assert property (@(posedge CLK) disable iff (RST)
      1'h1 |=> REMOTE_LOCKED == $past(locked))
      else $error("Lock status does not follow the lock.");
   next_key_a: assert property (@(posedge CLK) disable iff (RST)
      KEY_VALID && REMOTE_ENABLE && key_allowed(KEY_CODE) && !locked && REMOTE_LOCK_INPUT_WR |=> FB1_CMD_VALID)
      else $error("Key in flight lost to lock change.");
   lock_next_a: assert property (@(posedge CLK) disable iff (RST)
      LOCK_ENABLE && REMOTE_LOCK_INPUT_WR && (REMOTE_LOCK_INPUT ^ LOCK_POLARITY) && !SUPPLY_RETURN && !DOWNLOAD_DONE
      ##1 LOCK_ENABLE && !REMOTE_LOCK_INPUT_WR && !SUPPLY_RETURN && !DOWNLOAD_DONE
      ##1 KEY_VALID |=> !FB1_CMD_VALID)
      else $error("Key after a locking telegram passed.");

   // Routing: only accepted keys reach function block 1, with code and argument.
   route_fb1_a: assert property (@(posedge CLK) disable iff (RST)
      accept |=> FB1_CMD_VALID && FB1_CMD_CODE == $past(KEY_CODE) && FB1_CMD_ARG == $past(KEY_ARG))
      else $error("Accepted key not routed.");
   only_accepted_a: assert property (@(posedge CLK) disable iff (RST)
      !accept |=> !FB1_CMD_VALID && $stable(FB1_CMD_CODE) && $stable(FB1_CMD_ARG))
      else $error("Command port moved without an accepted key.");

   cover_pass_c:   cover property (@(posedge CLK) disable iff (RST) accept ##1 FB1_CMD_VALID);
   cover_flight_c: cover property (@(posedge CLK) disable iff (RST) accept && REMOTE_LOCK_INPUT_WR);
   cover_locked_c: cover property (@(posedge CLK) disable iff (RST) KEY_VALID && locked);
   cover_walk_c:   cover property (@(posedge CLK) disable iff (RST) $rose(FB1_WALK_TEST));
   cover_retain_c: cover property (@(posedge CLK) disable iff (RST) SUPPLY_RETURN && LOCK_START_SUPPLY == 2'h2);

endmodule : rklg_gate

/* test/rklg_far.sv */
// Far-side model: infrared key decoder and bus lock telegram sender.
`timescale 1ns/1ps
module rklg_far
(
   // Clock
   input  wire logic                       clk,
   // Decoded keys
   output logic                            key_valid,
   output logic [2:0]                      key_code,
   output logic [rklg_pkg::ARG_W-1:0]      key_arg,
   // Lock telegram
   output logic                            lock_wr,
   output logic                            lock_value
);
   initial
   begin
      key_valid  = 1'h0;
      key_code   = 3'h7;
      key_arg    = 8'hA5;
      lock_wr    = 1'h0;
      lock_value = 1'h1;
   end

   // Released data lines show the inverse and both strobes return to 0, so a stale value can never pass for a fresh one.
   task automatic send(input logic kv, input logic [2:0] kc, input logic [7:0] ka, input logic lw, input logic lv);
      @(negedge clk);
      key_valid  = kv;
      key_code   = kc;
      key_arg    = ka;
      lock_wr    = lw;
      lock_value = lv;
      @(negedge clk);
      key_valid  = 1'h0;
      key_code   = ~kc;
      key_arg    = ~ka;
      lock_wr    = 1'h0;
      lock_value = ~lv;
   endtask : send
endmodule : rklg_far

/* test/tb_top.sv */
// Self-checking testbench for the remote keypad lock gate.
`timescale 1ns/1ps
module tb_top;
   logic       clk = 1'h0;
   logic       rst = 1'h1;
   logic       ren = 1'h1, ton = 1'h1, tau = 1'h1, tof = 1'h1, tte = 1'h1;
   logic       len = 1'h0, lpol = 1'h0, ldl = 1'h0, sfail = 1'h0, sret = 1'h0, dl = 1'h0;
   logic [1:0] lsup = 2'h0;
   logic       kv, lw, lv, vld, walk, lkd;
   logic [2:0] kc, code;
   logic [7:0] ka, arg;
   int         bad_count = 0;
   int         check_count = 0;

   always #10 clk = ~clk;

   rklg_far far (.clk(clk), .key_valid(kv), .key_code(kc), .key_arg(ka), .lock_wr(lw), .lock_value(lv));

   rklg_gate uut (.CLK(clk), .RST(rst), .REMOTE_ENABLE(ren), .KEY_ON_ENABLE(ton), .KEY_AUTO_ENABLE(tau),
      .KEY_OFF_ENABLE(tof), .KEY_TEST_ENABLE(tte), .LOCK_ENABLE(len), .LOCK_POLARITY(lpol),
      .LOCK_START_SUPPLY(lsup), .LOCK_START_DOWNLOAD(ldl), .REMOTE_LOCK_INPUT_WR(lw), .REMOTE_LOCK_INPUT(lv),
      .SUPPLY_FAIL(sfail), .SUPPLY_RETURN(sret), .DOWNLOAD_DONE(dl), .KEY_VALID(kv), .KEY_CODE(kc),
      .KEY_ARG(ka), .FB1_CMD_VALID(vld), .FB1_CMD_CODE(code), .FB1_CMD_ARG(arg), .FB1_WALK_TEST(walk),
      .REMOTE_LOCKED(lkd));

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         $display("BAD %s expected %h seen %h", what, exp, seen);
         bad_count++;
      end
   endtask : chk

   // A key is checked half a cycle after it is taken, while the command pulse stands.
   task automatic key(input logic [2:0] c, input logic pass);
      far.send(1'h1, c, 8'h3C ^ {5'h00, c}, 1'h0, 1'h0);
      chk("cmd_valid", {7'h00, vld}, {7'h00, pass});
      if (pass)
      begin
         chk("cmd_code", {5'h00, code}, {5'h00, c});
         chk("cmd_arg", arg, 8'h3C ^ {5'h00, c});
      end
   endtask : key

   task automatic ev(input logic f, input logic r, input logic d);
      @(negedge clk);
      sfail = f;
      sret  = r;
      dl    = d;
      @(negedge clk);
      sfail = 1'h0;
      sret  = 1'h0;
      dl    = 1'h0;
   endtask : ev

   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : complete_run

   initial
   begin
      #40000;
      bad_count++;
      complete_run();
   end

   initial
   begin
      repeat (5) @(negedge clk);
      rst = 1'h0;
      chk("idle", {5'h00, vld, walk, lkd}, 8'h00);
      for (int c = 1; c <= 5; c++) key(c[2:0], 1'h1);
      chk("walk_on", {7'h00, walk}, 8'h01);
      for (int i = 0; i < 3; i++)
      begin
         {tof, tau, ton} = ~(3'h1 << i);
         key(i[2:0] + 3'h1, 1'h0);
      end
      {tof, tau, ton} = 3'h7;
      tte = 1'h0;
      key(3'h4, 1'h0);
      chk("walk_kept", {7'h00, walk}, 8'h01);
      tte = 1'h1;
      key(3'h4, 1'h1);
      chk("walk_off", {7'h00, walk}, 8'h00);
      key(3'h4, 1'h1);
      chk("walk_again", {7'h00, walk}, 8'h01);
      ren = 1'h0;
      key(3'h1, 1'h0);
      chk("walk_clr", {7'h00, walk}, 8'h00);
      ren = 1'h1;
      far.send(1'h0, 3'h0, 8'h00, 1'h1, 1'h1);
      key(3'h1, 1'h1);
      chk("lock_off", {7'h00, lkd}, 8'h00);
      len = 1'h1;
      for (int p = 0; p < 2; p++)
      begin
         lpol = p[0];
         far.send(1'h0, 3'h0, 8'h00, 1'h1, ~p[0]);
         key(3'h2, 1'h0);
         chk("locked", {7'h00, lkd}, 8'h01);
         far.send(1'h0, 3'h0, 8'h00, 1'h1, p[0]);
         key(3'h2, 1'h1);
      end
      // Key and locking telegram on one edge: the key still uses the old state.
      far.send(1'h1, 3'h3, 8'h3F, 1'h1, 1'h0);
      chk("inflight", {7'h00, vld}, 8'h01);
      key(3'h3, 1'h0);
      ev(1'h0, 1'h1, 1'h0);
      key(3'h1, 1'h1);
      lsup = 2'h1;
      ev(1'h0, 1'h1, 1'h0);
      key(3'h1, 1'h0);
      lsup = 2'h2;
      ev(1'h1, 1'h0, 1'h0);
      far.send(1'h0, 3'h0, 8'h00, 1'h1, 1'h1);
      key(3'h1, 1'h1);
      ev(1'h0, 1'h1, 1'h0);
      key(3'h1, 1'h0);
      chk("retained", {7'h00, lkd}, 8'h01);
      ev(1'h0, 1'h0, 1'h1);
      key(3'h1, 1'h1);
      ldl = 1'h1;
      ev(1'h0, 1'h0, 1'h1);
      key(3'h1, 1'h0);
      complete_run();
   end
endmodule : tb_top
